// ==== core/ifap_port.sv ====
// Host bus access port: resource registers, receive and transmit frame windows
`default_nettype none
// Function
// - Memory decoding off while memory base is zero; resets to zero without EEPROM.
// - I/O base starts sixteen port bytes; I/O decoding off while it is zero.
// - Resource registers load from EEPROM when found, else reset to zero.
// - Interrupt drives the request line numbered by the select register, valid codes only.
// - Select low bits zero: all interrupt outputs floating, no interrupts.
// - DMA select 5 to 7 uses that channel; 8 floats every request.
// - DMA select resets to zero; DMA interface stays inactive meanwhile.
// - Exactly one receive and one transmit frame are visible at a time.
// - I/O data port returns status, length, then frame data in sequence.
// - Memory mode receive block: status 400h, length 402h, data from 404h.
// - Random even word reads in first 118 bytes; everything else sequential.
// - Event register mirrors receive status and clears when read.
// - Length includes CRC only when CRC is kept in the buffer.
// - Frame released on event read, skip command, or fully read.
// - Transmit data taken by sequential writes from offset 0A00h.
// - Word and byte transfers in I/O and memory space on 16-bit bus.
// - Memory cycle claimed on LA/SA base match, enable set, no refresh or AEN.
// - I/O mode has eight 16-bit ports; data port at offset zero.
module ifap_port #(
  parameter int BUF_AW = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host bus pins
  input wire logic [16:0] sa,
  input wire logic [23:17] la,
  input wire logic bale,
  input wire logic aen,
  input wire logic refresh,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic sbhe_n,
  input wire logic [15:0] sd_in,
  output logic [15:0] sd_out,
  output logic sd_oe,
  // Interrupt and DMA pins
  output logic [15:0] irq_out,
  output logic [15:0] irq_oe,
  output logic [7:5] drq_out,
  output logic [7:5] drq_oe,
  // EEPROM load
  input wire logic ee_load,
  input wire logic [15:0] ee_mem_base,
  input wire logic [15:0] ee_io_base,
  input wire logic [15:0] ee_irq_sel,
  input wire logic [15:0] ee_dma_sel,
  // Core configuration and requests
  input wire logic memory_space_enable,
  input wire logic keep_crc_in_buffer,
  input wire logic irq_req,
  input wire logic dma_req,
  // Receive frame from the buffer
  input wire logic rx_new,
  input wire logic [15:0] rx_status,
  input wire logic [15:0] rx_len_raw,
  input wire logic skip_cmd,
  input wire logic [15:0] rx_rd_data,
  output logic [BUF_AW-1:0] rx_rd_addr,
  output logic rx_release,
  // Transmit frame to the buffer
  input wire logic tx_new,
  output logic tx_wr_en,
  output logic [BUF_AW-1:0] tx_wr_addr,
  output logic [15:0] tx_wr_data,
  output logic [1:0] tx_wr_be
);
  generate
    if (BUF_AW < 8 || BUF_AW > 16) begin : g_bad_aw
      $error("ifap_port: BUF_AW must be 8 to 16");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisation and address latch
  // ----------------------------------------
  logic [47:0] syn;
  logic [16:0] s_sa;
  logic [6:0] s_la;
  logic s_bale, s_aen, s_refresh, s_ior_n, s_iow_n, s_memr_n, s_memw_n, s_sbhe_n;
  logic [15:0] s_sd;
  logic [6:0] la_q;

  ifap_sync #(.W(48), .RST(ifap_pkg::PIN_RESET)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .d({sa, la, bale, aen, refresh, ior_n, iow_n, memr_n, memw_n, sbhe_n, sd_in}),
    .q(syn)
  );
  assign {s_sa, s_la, s_bale, s_aen, s_refresh, s_ior_n, s_iow_n, s_memr_n, s_memw_n, s_sbhe_n, s_sd} = syn;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      la_q <= '0;
    end else if (s_bale) begin
      la_q <= s_la;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] memory_window_base, io_window_base, interrupt_line_select, dma_channel_select;
  logic [15:0] page_ptr;
  logic [15:0] rx_event;
  logic rx_avail;
  ifap_pkg::ifap_state_e st;
  logic sel_frame, src_odd, acc_word, acc_odd;
  logic [15:0] hold_word;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic io_hit, mem_hit, rd_req, wr_req, is_word, data_port, pdata;
  logic [2:0] io_port;
  logic [11:0] pa;
  logic [1:0] lanes;
  logic rx_zone, tx_zone, rx_rand, rx_step, tx_step, seq_end, ev_read, release_now;
  logic [15:0] len_shown, blk, blk_next, reg_word;

  ifap_ptr_if #(.W(16)) rx_p ();
  ifap_ptr_if #(.W(16)) tx_p ();
  ifap_seq_ptr #(.W(16)) u_rx_ptr (.mclk(mclk), .reset(reset), .p(rx_p));
  ifap_seq_ptr #(.W(16)) u_tx_ptr (.mclk(mclk), .reset(reset), .p(tx_p));

  assign io_hit = !s_aen && io_window_base != 16'h0000 && s_sa[15:4] == io_window_base[15:4];
  assign mem_hit = memory_window_base != 16'h0000 && memory_space_enable && !s_refresh && !s_aen
    && la_q == memory_window_base[15:9] && s_sa[16:12] == memory_window_base[8:4];
  assign rd_req = (mem_hit && !s_memr_n) || (io_hit && !mem_hit && !s_ior_n);
  assign wr_req = (mem_hit && !s_memw_n) || (io_hit && !mem_hit && !s_iow_n);
  assign is_word = !s_sbhe_n && !s_sa[0];
  assign lanes = is_word ? 2'b11 : (s_sa[0] ? 2'b10 : 2'b01);
  assign io_port = s_sa[3:1];
  assign data_port = !mem_hit && io_port == ifap_pkg::IOP_DATA;
  assign pdata = !mem_hit && (io_port == ifap_pkg::IOP_PDATA0 || io_port == ifap_pkg::IOP_PDATA1);

  always_comb begin
    pa = 12'h000;
    if (mem_hit) begin
      pa = s_sa[11:0];
    end else begin
      case (io_port)
        ifap_pkg::IOP_PDATA0: pa = page_ptr[11:0];
        ifap_pkg::IOP_PDATA1: pa = page_ptr[11:0] + 12'h002;
        ifap_pkg::IOP_ISQ: pa = ifap_pkg::PG_RX_EVENT;
        default: pa = 12'h000;
      endcase
    end
  end

  assign rx_zone = data_port || ((mem_hit || pdata) && pa >= ifap_pkg::PG_RX_STATUS && pa < ifap_pkg::PG_TX_FRAME);
  assign tx_zone = data_port || ((mem_hit || pdata) && pa >= ifap_pkg::PG_TX_FRAME);
  assign rx_rand = mem_hit && is_word && !pa[0] && pa < ifap_pkg::PG_RX_FRAME + ifap_pkg::RX_RANDOM_BYTES;
  assign len_shown = keep_crc_in_buffer ? rx_len_raw : rx_len_raw - ifap_pkg::CRC_BYTES;
  assign blk = rx_rand ? {4'h0, pa - ifap_pkg::PG_RX_STATUS} : rx_p.ptr;
  assign blk_next = rx_p.ptr + (is_word ? 16'h0002 : 16'h0001);
  assign seq_end = blk_next >= len_shown + ifap_pkg::RX_HDR_BYTES;
  assign rx_step = st == ifap_pkg::ST_IDLE && rd_req && rx_zone && rx_avail && !rx_rand;
  assign tx_step = st == ifap_pkg::ST_IDLE && wr_req && tx_zone;
  assign ev_read = st == ifap_pkg::ST_IDLE && rd_req && !rx_zone && pa == ifap_pkg::PG_RX_EVENT;
  assign release_now = (rx_step && seq_end) || (ev_read && rx_avail) || skip_cmd;

  assign rx_p.clear = rx_new || release_now;
  assign rx_p.step = rx_step;
  assign rx_p.two = is_word;
  assign tx_p.clear = tx_new;
  assign tx_p.step = tx_step;
  assign tx_p.two = is_word;

  always_comb begin
    reg_word = 16'h0000;
    if (!mem_hit && io_port == ifap_pkg::IOP_PTR) begin
      reg_word = page_ptr;
    end else begin
      case (pa)
        ifap_pkg::PG_MEM_BASE: reg_word = memory_window_base;
        ifap_pkg::PG_IO_BASE: reg_word = io_window_base;
        ifap_pkg::PG_IRQ_SEL: reg_word = interrupt_line_select;
        ifap_pkg::PG_DMA_SEL: reg_word = dma_channel_select;
        ifap_pkg::PG_RX_EVENT: reg_word = rx_event;
        default: reg_word = 16'h0000;
      endcase
    end
  end

  function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
    lane_write = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] place(input logic [15:0] w, input logic word, input logic so, input logic dodd);
    logic [7:0] b;
    b = so ? w[15:8] : w[7:0];
    if (word) begin
      place = w;
    end else begin
      place = dodd ? {b, 8'h00} : {8'h00, b};
    end
  endfunction

  // ----------------------------------------
  // Resource registers
  // ----------------------------------------
  logic reg_wr;
  assign reg_wr = st == ifap_pkg::ST_IDLE && wr_req && !tx_zone && (mem_hit || pdata);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      memory_window_base <= ifap_pkg::REG_RESET;
      io_window_base <= ifap_pkg::REG_RESET;
      interrupt_line_select <= ifap_pkg::REG_RESET;
      dma_channel_select <= ifap_pkg::REG_RESET;
    end else if (ee_load) begin
      memory_window_base <= ee_mem_base;
      io_window_base <= ee_io_base;
      interrupt_line_select <= ee_irq_sel;
      dma_channel_select <= ee_dma_sel;
    end else if (reg_wr) begin
      case (pa)
        ifap_pkg::PG_MEM_BASE: memory_window_base <= lane_write(memory_window_base, s_sd, lanes);
        ifap_pkg::PG_IO_BASE: io_window_base <= lane_write(io_window_base, s_sd, lanes);
        ifap_pkg::PG_IRQ_SEL: interrupt_line_select <= lane_write(interrupt_line_select, s_sd, lanes);
        ifap_pkg::PG_DMA_SEL: dma_channel_select <= lane_write(dma_channel_select, s_sd, lanes);
        default: ;
      endcase
    end
  end

  // Page pointer with auto-increment after each page data port access
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      page_ptr <= ifap_pkg::REG_RESET;
    end else if (st == ifap_pkg::ST_IDLE && wr_req && !mem_hit && io_port == ifap_pkg::IOP_PTR) begin
      page_ptr <= lane_write(page_ptr, s_sd, lanes);
    end else if (st == ifap_pkg::ST_IDLE && (rd_req || wr_req) && pdata && page_ptr[ifap_pkg::PTR_AUTOINC_BIT]) begin
      page_ptr[11:0] <= page_ptr[11:0] + 12'h002;
    end
  end

  // ----------------------------------------
  // Current receive frame
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_avail <= 1'b0;
      rx_event <= 16'h0000;
      rx_release <= 1'b0;
    end else begin
      rx_release <= release_now;
      if (rx_new) begin
        rx_avail <= 1'b1;
      end else if (release_now) begin
        rx_avail <= 1'b0;
      end
      if (rx_new) begin
        rx_event <= rx_status;
      end else if (ev_read) begin
        rx_event <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  logic strobes_idle;
  assign strobes_idle = s_ior_n && s_iow_n && s_memr_n && s_memw_n;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= ifap_pkg::ST_IDLE;
      sd_oe <= 1'b0;
      sd_out <= 16'h0000;
      sel_frame <= 1'b0;
      src_odd <= 1'b0;
      acc_word <= 1'b0;
      acc_odd <= 1'b0;
      hold_word <= 16'h0000;
      rx_rd_addr <= '0;
    end else begin
      case (st)
        ifap_pkg::ST_IDLE: begin
          if (rd_req) begin
            st <= ifap_pkg::ST_FETCH;
            sd_oe <= 1'b1;
            acc_word <= is_word;
            acc_odd <= s_sa[0];
            sel_frame <= rx_zone && rx_avail && blk >= ifap_pkg::RX_HDR_BYTES;
            src_odd <= rx_zone ? blk[0] : s_sa[0];
            rx_rd_addr <= BUF_AW'(blk - ifap_pkg::RX_HDR_BYTES);
            if (!rx_zone) begin
              hold_word <= reg_word;
            end else if (!rx_avail) begin
              hold_word <= 16'h0000;
            end else begin
              hold_word <= blk[1] ? len_shown : rx_status;
            end
          end else if (wr_req) begin
            st <= ifap_pkg::ST_WAIT;
          end
        end
        ifap_pkg::ST_FETCH: begin
          sd_out <= place(sel_frame ? rx_rd_data : hold_word, acc_word, src_odd, acc_odd);
          st <= ifap_pkg::ST_DRIVE;
        end
        ifap_pkg::ST_DRIVE: begin
          if (strobes_idle) begin
            sd_oe <= 1'b0;
            st <= ifap_pkg::ST_IDLE;
          end
        end
        ifap_pkg::ST_WAIT: begin
          if (strobes_idle) begin
            st <= ifap_pkg::ST_IDLE;
          end
        end
        default: st <= ifap_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit window writes
  // ----------------------------------------
  logic [7:0] wr_byte;
  assign wr_byte = s_sa[0] ? s_sd[15:8] : s_sd[7:0];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_wr_en <= 1'b0;
      tx_wr_addr <= '0;
      tx_wr_data <= 16'h0000;
      tx_wr_be <= 2'b00;
    end else begin
      tx_wr_en <= tx_step;
      if (tx_step) begin
        tx_wr_addr <= tx_p.ptr[BUF_AW-1:0];
        tx_wr_data <= is_word ? s_sd : {wr_byte, wr_byte};
        tx_wr_be <= is_word ? 2'b11 : (tx_p.ptr[0] ? 2'b10 : 2'b01);
      end
    end
  end

  // ----------------------------------------
  // Interrupt and DMA line steering
  // ----------------------------------------
  function automatic logic irq_code_ok(input logic [3:0] n);
    case (n)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: irq_code_ok = 1'b1;
      default: irq_code_ok = 1'b0;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          irq_oe[gi] <= 1'b0;
          irq_out[gi] <= 1'b0;
        end else begin
          irq_oe[gi] <= irq_code_ok(interrupt_line_select[3:0]) && interrupt_line_select[3:0] == 4'(gi);
          irq_out[gi] <= irq_req && irq_code_ok(interrupt_line_select[3:0]) && interrupt_line_select[3:0] == 4'(gi);
        end
      end
    end
    for (gi = 5; gi < 8; gi++) begin : g_drq
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          drq_oe[gi] <= 1'b0;
          drq_out[gi] <= 1'b0;
        end else begin
          drq_oe[gi] <= dma_channel_select[3:0] == 4'(gi) && dma_channel_select[15:4] == 12'h000;
          drq_out[gi] <= dma_req && dma_channel_select[3:0] == 4'(gi) && dma_channel_select[15:4] == 12'h000;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== inc/ifap_pkg.sv ====
// Constants shared by the frame access port: page offsets, I/O ports, reset values and codes
`default_nettype none
package ifap_pkg;
  // ----------------------------------------
  // Page offsets of the host-visible locations
  // ----------------------------------------
  localparam logic [11:0] PG_RX_EVENT = 12'h124;
  localparam logic [11:0] PG_MEM_BASE = 12'h348;
  localparam logic [11:0] PG_IO_BASE = 12'h360;
  localparam logic [11:0] PG_IRQ_SEL = 12'h370;
  localparam logic [11:0] PG_DMA_SEL = 12'h374;
  localparam logic [11:0] PG_RX_STATUS = 12'h400;
  localparam logic [11:0] PG_RX_LENGTH = 12'h402;
  localparam logic [11:0] PG_RX_FRAME = 12'h404;
  localparam logic [11:0] PG_TX_FRAME = 12'ha00;
  // ----------------------------------------
  // Receive block layout
  // ----------------------------------------
  localparam logic [15:0] RX_HDR_BYTES = 16'h0004;
  localparam logic [11:0] RX_RANDOM_BYTES = 12'h076;
  localparam logic [15:0] CRC_BYTES = 16'h0004;
  // ----------------------------------------
  // I/O port index (address bits 3:1)
  // ----------------------------------------
  localparam logic [2:0] IOP_DATA = 3'h0;
  localparam logic [2:0] IOP_ISQ = 3'h4;
  localparam logic [2:0] IOP_PTR = 3'h5;
  localparam logic [2:0] IOP_PDATA0 = 3'h6;
  localparam logic [2:0] IOP_PDATA1 = 3'h7;
  localparam int PTR_AUTOINC_BIT = 15;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [47:0] PIN_RESET = 48'h0000_001f_0000;
  localparam logic [3:0] DMA_FIRST = 4'h5;
  localparam logic [3:0] DMA_LAST = 4'h7;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_DRIVE = 2'b10,
    ST_WAIT = 2'b11
  } ifap_state_e;
endpackage
`default_nettype wire

// ==== inc/ifap_ptr_if.sv ====
// Control and value of one sequential byte pointer
`default_nettype none
interface ifap_ptr_if #(parameter int W = 16);
  logic clear;
  logic step;
  logic two;
  logic [W-1:0] ptr;
  modport owner (output clear, output step, output two, input ptr);
  modport counter (input clear, input step, input two, output ptr);
endinterface
`default_nettype wire

// ==== core/ifap_sync.sv ====
// Two-stage synchroniser for the bus pins
`default_nettype none
module ifap_sync #(
  parameter int W = 48,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== core/ifap_seq_ptr.sv ====
// Sequential byte pointer that steps by one or two bytes
`default_nettype none
module ifap_seq_ptr #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pointer control
  ifap_ptr_if.counter p
);
  generate
    if (W < 4 || W > 16) begin : g_bad_width
      $error("ifap_seq_ptr: W must be 4 to 16");
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      p.ptr <= '0;
    end else if (p.clear) begin
      p.ptr <= '0;
    end else if (p.step) begin
      p.ptr <= p.ptr + (p.two ? W'(2) : W'(1));
    end
  end
endmodule
`default_nettype wire

// ==== sim/ifap_port_asserts.sv ====
// Concurrent checks on the frame access port pins
`default_nettype none
module ifap_port_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host strobes and config
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic memory_space_enable,
  // Observed outputs
  input wire logic sd_oe,
  input wire logic [15:0] irq_out,
  input wire logic [15:0] irq_oe,
  input wire logic [7:5] drq_out,
  input wire logic [7:5] drq_oe,
  input wire logic rx_release,
  input wire logic tx_wr_en,
  input wire logic [1:0] tx_wr_be
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_drive_cause;
    $rose(sd_oe) |-> (!$past(memr_n, 2) || !$past(ior_n, 2));
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("read data driven without a read strobe");
  property p_idle_float;
    (ior_n && memr_n) [*6] |-> !sd_oe;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("data bus driven while idle");
  property p_mem_off;
    (!memory_space_enable && ior_n && iow_n) [*6] |-> !sd_oe;
  endproperty
  a_mem_off: assert property (p_mem_off) else $error("memory cycle claimed while disabled");
  property p_tx_cause;
    tx_wr_en |-> (!$past(memw_n, 2) || !$past(iow_n, 2));
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("transmit write without host write");
  property p_tx_be;
    tx_wr_en |-> tx_wr_be != 2'h0;
  endproperty
  a_tx_be: assert property (p_tx_be) else $error("transmit write with no byte lane");
  property p_rel_pulse;
    rx_release |=> !rx_release;
  endproperty
  a_rel_pulse: assert property (p_rel_pulse) else $error("release held longer than a cycle");
  property p_irq_sel;
    $onehot0(irq_oe) && ((irq_oe & ~16'hdef8) == 16'h0000);
  endproperty
  a_irq_sel: assert property (p_irq_sel) else $error("interrupt driven on an invalid line");
  property p_irq_float;
    (irq_out & ~irq_oe) == 16'h0000;
  endproperty
  a_irq_float: assert property (p_irq_float) else $error("interrupt raised on a floating line");
  property p_drq_sel;
    $onehot0(drq_oe) && ((drq_out & ~drq_oe) == 3'h0);
  endproperty
  a_drq_sel: assert property (p_drq_sel) else $error("DMA request on an unselected channel");
endmodule
bind ifap_port ifap_port_asserts chk_u (.mclk, .reset, .ior_n, .iow_n, .memr_n, .memw_n, .memory_space_enable,
  .sd_oe, .irq_out, .irq_oe, .drq_out, .drq_oe, .rx_release, .tx_wr_en, .tx_wr_be);
`default_nettype wire

// ==== sim/ifap_buf_model.sv ====
// Buffer memory model: byte n of a frame holds value n, keeps the last transmit write
`default_nettype none
module ifap_buf_model #(
  parameter int AW = 12
) (
  // Clock
  input wire logic mclk,
  // Receive read side
  input wire logic [AW-1:0] rx_rd_addr,
  output logic [15:0] rx_rd_data,
  // Transmit write side
  input wire logic tx_wr_en,
  input wire logic [AW-1:0] tx_wr_addr,
  input wire logic [15:0] tx_wr_data,
  input wire logic [1:0] tx_wr_be,
  output logic [AW-1:0] last_addr,
  output logic [15:0] last_data,
  output logic [1:0] last_be
);
  logic [7:0] even_b;
  assign even_b = {rx_rd_addr[7:1], 1'b0};
  assign rx_rd_data = {even_b + 8'h01, even_b};
  always @(posedge mclk) begin
    if (tx_wr_en) begin
      last_addr <= tx_wr_addr;
      last_data <= tx_wr_data;
      last_be <= tx_wr_be;
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_isa_frame_access_port.sv ====
// Self-checking bench for the frame access port
`default_nettype none
module tb_isa_frame_access_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, bale = 1, aen = 0, refresh = 0, irq_req = 1, dma_req = 1;
  logic ior_n = 1, iow_n = 1, memr_n = 1, memw_n = 1, sbhe_n = 1, ee_load = 0, memory_space_enable = 1;
  logic keep_crc_in_buffer = 1, rx_new = 0, skip_cmd = 0, tx_new = 0, sd_oe, rx_release, tx_wr_en, oe_seen;
  logic [16:0] sa = '0;
  logic [23:17] la = '0;
  logic [15:0] sd_in = '0, rx_status = '0, rx_len_raw = '0, sd_out, irq_out, irq_oe, rx_rd_data, tx_wr_data, q;
  logic [15:0] ee_mem_base = 16'h0c80, ee_io_base = 16'h0300, ee_irq_sel = 16'h0005, ee_dma_sel = 16'h0006;
  logic [7:5] drq_out, drq_oe;
  logic [11:0] rx_rd_addr, tx_wr_addr, last_addr;
  logic [1:0] tx_wr_be, last_be;
  logic [15:0] last_data;
  int n_errors = 0, tests_run = 0, n_rel = 0, cycles = 0;
  always #20 mclk = ~mclk;
  ifap_port #(.BUF_AW(12)) dut_u (.mclk(mclk), .reset(reset), .sa(sa), .la(la), .bale(bale), .aen(aen),
    .refresh(refresh), .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .sbhe_n(sbhe_n),
    .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .irq_out(irq_out), .irq_oe(irq_oe), .drq_out(drq_out),
    .drq_oe(drq_oe), .ee_load(ee_load), .ee_mem_base(ee_mem_base), .ee_io_base(ee_io_base),
    .ee_irq_sel(ee_irq_sel), .ee_dma_sel(ee_dma_sel), .memory_space_enable(memory_space_enable),
    .keep_crc_in_buffer(keep_crc_in_buffer), .irq_req(irq_req), .dma_req(dma_req), .rx_new(rx_new),
    .rx_status(rx_status), .rx_len_raw(rx_len_raw), .skip_cmd(skip_cmd), .rx_rd_data(rx_rd_data),
    .rx_rd_addr(rx_rd_addr), .rx_release(rx_release), .tx_new(tx_new), .tx_wr_en(tx_wr_en),
    .tx_wr_addr(tx_wr_addr), .tx_wr_data(tx_wr_data), .tx_wr_be(tx_wr_be));
  ifap_buf_model #(.AW(12)) bm_u (.mclk(mclk), .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data),
    .tx_wr_en(tx_wr_en), .tx_wr_addr(tx_wr_addr), .tx_wr_data(tx_wr_data), .tx_wr_be(tx_wr_be),
    .last_addr(last_addr), .last_data(last_data), .last_be(last_be));
  always @(posedge mclk) begin
    cycles++;
    if (rx_release === 1'b1) n_rel++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One host cycle: strobe low six cycles, then high six cycles
  task automatic bus(input logic mem, input logic wr, input logic [16:0] a, input logic wd, input logic [15:0] d);
    @(posedge mclk);
    #1 sa = a;
    la = 7'h06;
    sbhe_n = ~(wd | a[0]);
    sd_in = d;
    oe_seen = 0;
    if (mem) {memr_n, memw_n} = {wr, ~wr};
    else {ior_n, iow_n} = {wr, ~wr};
    repeat (6) begin
      @(posedge mclk);
      #1 oe_seen = oe_seen | sd_oe;
    end
    q = sd_out;
    {ior_n, iow_n, memr_n, memw_n} = 4'hf;
    repeat (6) @(posedge mclk);
  endtask
  task automatic mrd(input logic [11:0] p, input logic wd);
    bus(1, 0, {5'h08, p}, wd, 16'h0000);
  endtask
  task automatic mwr(input logic [11:0] p, input logic wd, input logic [15:0] d);
    bus(1, 1, {5'h08, p}, wd, d);
  endtask
  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1;
    @(posedge mclk);
    #1 s = 0;
  endtask
  task automatic frame(input logic [15:0] st, input logic [15:0] ln);
    @(posedge mclk);
    #1 rx_status = st;
    rx_len_raw = ln;
    pulse(rx_new);
  endtask
  task automatic t_reset;
    chk(irq_oe, 16'h0000);
    chk({13'h0, drq_oe}, 16'h0000);
    mrd(12'h348, 1);
    chk({15'h0, oe_seen}, 16'h0000);
    bus(0, 0, 17'h00300, 1, 16'h0000);
    chk({15'h0, oe_seen}, 16'h0000);
    pulse(ee_load);
    mrd(12'h348, 1);
    chk(q, 16'h0c80);
    mrd(12'h360, 1);
    chk(q, 16'h0300);
    mrd(12'h370, 1);
    chk(q, 16'h0005);
    chk(irq_oe, 16'h0020);
    chk(irq_out, 16'h0020);
    chk({10'h0, drq_oe, drq_out}, 16'h0012);
    $display("test reset done");
  endtask
  task automatic t_select;
    mwr(12'h370, 1, 16'h000f);
    chk(irq_oe, 16'h8000);
    mwr(12'h370, 1, 16'h0000);
    chk(irq_oe | irq_out, 16'h0000);
    mwr(12'h374, 1, 16'h0007);
    chk({13'h0, drq_oe}, 16'h0004);
    mwr(12'h374, 1, 16'h0008);
    chk({13'h0, drq_oe}, 16'h0000);
    mwr(12'h374, 1, 16'h0000);
    chk({13'h0, drq_oe}, 16'h0000);
    #1 memory_space_enable = 0;
    mrd(12'h348, 1);
    chk({15'h0, oe_seen}, 16'h0000);
    #1 memory_space_enable = 1;
    refresh = 1;
    mrd(12'h348, 1);
    chk({15'h0, oe_seen}, 16'h0000);
    #1 refresh = 0;
    aen = 1;
    bus(0, 0, 17'h00300, 1, 16'h0000);
    chk({15'h0, oe_seen}, 16'h0000);
    #1 aen = 0;
    $display("test select done");
  endtask
  task automatic t_mem_rx;
    int r0;
    frame(16'h1234, 16'h000c);
    mrd(12'h400, 1);
    chk(q, 16'h1234);
    mrd(12'h402, 1);
    chk(q, 16'h000c);
    mrd(12'h406, 1);
    chk(q, 16'h0302);
    mrd(12'h404, 1);
    chk(q, 16'h0100);
    r0 = n_rel;
    mrd(12'h124, 1);
    chk(q, 16'h1234);
    chk(16'(n_rel - r0), 16'h0001);
    mrd(12'h124, 1);
    chk(q, 16'h0000);
    mrd(12'h400, 1);
    chk(q, 16'h0000);
    $display("test memory receive done");
  endtask
  task automatic t_io_rx;
    int r0;
    #1 keep_crc_in_buffer = 0;
    frame(16'h0055, 16'h0008);
    r0 = n_rel;
    bus(0, 0, 17'h00300, 1, 16'h0000);
    chk(q, 16'h0055);
    bus(0, 0, 17'h00300, 1, 16'h0000);
    chk(q, 16'h0004);
    bus(0, 0, 17'h00300, 1, 16'h0000);
    chk(q, 16'h0100);
    bus(0, 0, 17'h00300, 0, 16'h0000);
    chk({8'h00, q[7:0]}, 16'h0002);
    bus(0, 0, 17'h00301, 0, 16'h0000);
    chk({8'h00, q[15:8]}, 16'h0003);
    chk(16'(n_rel - r0), 16'h0001);
    frame(16'h0077, 16'h0010);
    pulse(skip_cmd);
    repeat (3) @(posedge mclk);
    chk(16'(n_rel - r0), 16'h0002);
    frame(16'h0099, 16'h0010);
    bus(0, 0, 17'h00308, 1, 16'h0000);
    chk(q, 16'h0099);
    chk(16'(n_rel - r0), 16'h0003);
    bus(0, 1, 17'h0030a, 1, 16'h0348);
    bus(0, 0, 17'h0030c, 1, 16'h0000);
    chk(q, 16'h0c80);
    $display("test io receive done");
  endtask
  task automatic t_tx;
    pulse(tx_new);
    mwr(12'ha00, 1, 16'hbeef);
    chk({last_be, 2'h0, last_addr}, 16'hc000);
    chk(last_data, 16'hbeef);
    mwr(12'ha02, 0, 16'h0011);
    chk({last_be, 2'h0, last_addr}, 16'h4002);
    chk({8'h00, last_data[7:0]}, 16'h0011);
    mwr(12'ha03, 0, 16'h2200);
    chk({last_be, 2'h0, last_addr}, 16'h8003);
    chk({8'h00, last_data[15:8]}, 16'h0022);
    bus(0, 1, 17'h00300, 1, 16'h5566);
    chk({last_be, 2'h0, last_addr}, 16'hc004);
    chk(last_data, 16'h5566);
    $display("test transmit done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    #1 reset = 0;
    t_reset();
    t_select();
    t_mem_rx();
    t_io_rx();
    t_tx();
    close_out();
  end
endmodule
`default_nettype wire
